// >>> ptc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// R01 - The sense unit priority sits in bits 6-4 of its priority word, 111 is level 7 and 001 level 1.
// R02 - A source whose priority code is 000 is disabled and is never granted.
// R03 - Reset loads every user source priority with level 4.
// R04 - Priority word bits 15-7 and 3-0 read as zero and ignore writes.
// R05 - The status word shows the new CPU level in bits 11-8, bits 15-12 read zero.
// R06 - The status word shows the pending vector code in bits 6-0 (code 0 is vector 8), bit 7 reads zero.
// R07 - With nesting disable set, no user interrupt preempts one in service.
// R08 - A source requests only while both its enable and its flag are set.
// R09 - A flag stays set until software clears it, so the source is granted again after return.
// R10 - Return restores the saved status low byte and the CPU level in force before the grant.
// R11 - Each trap has a sticky flag and is taken again after return while that flag stays set.
// R12 - Raising the status low byte level to 7 by OR-ing 0Eh masks every user source.
// R13 - Trap levels 12 to 15 ignore every disable; only a CPU level at or above their own holds them, user levels are masked too.
// R14 - The timed disable blocks levels 1 to 6 for the programmed cycle count; level 7 still passes.
// R15 - A request is granted only above the CPU level; highest level wins, ties go to the lowest vector.
// R16 - On a grant the CPU level becomes the granted level and the status fields follow in the same cycle.

module ptc_ctrl (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [ptc_pkg::NUM_SRC-1:0] src_evt,
   input wire logic [ptc_pkg::NUM_TRAP-1:0] trap_evt,
   input wire logic cpu_take,
   input wire logic cpu_return,
   output logic cpu_irq,
   output logic [6:0] cpu_vector_code,
   output logic [3:0] cpu_level,
   output logic irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ap_valid;
      logic ap_write;
      logic [7:0] ap_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic nesting_disable;
      logic [ptc_pkg::NUM_TRAP-1:0] trap_flag;
      logic [ptc_pkg::NUM_SRC-1:0] flag;
      logic [ptc_pkg::NUM_SRC-1:0] en;
      logic [ptc_pkg::NUM_SRC-1:0][2:0] prio;
      logic [7:0] stat_low;
      logic [ptc_pkg::STACK_AW:0] depth;
      logic [15:0] tdis_cnt;
      logic [3:0] new_cpu_level;
      logic [6:0] pending_vector_code;
      logic [3:0] pend_lvl;
      logic cpu_irq;
      logic [2:0] evt_st;
      logic [2:0] evt_mask;
      logic irq;
   } ptc_state_s;

   localparam ptc_state_s RST = '{
      ap_valid: 1'b0,
      ap_write: 1'b0,
      ap_addr: 8'h00,
      hrdata: 32'h0000_0000,
      hreadyout: 1'b1,
      hresp: 1'b0,
      nesting_disable: 1'b0,
      trap_flag: '0,
      flag: '0,
      en: '0,
      prio: {ptc_pkg::NUM_SRC{ptc_pkg::PRIO_RESET}}, // R03
      stat_low: ptc_pkg::STAT_LOW_RESET,
      depth: '0,
      tdis_cnt: ptc_pkg::TDIS_RESET,
      new_cpu_level: 4'h0,
      pending_vector_code: 7'h00,
      pend_lvl: 4'h0,
      cpu_irq: 1'b0,
      evt_st: 3'h0,
      evt_mask: ptc_pkg::EVT_MASK_RESET,
      irq: 1'b0
   };

   ptc_state_s s;
   ptc_state_s next_s;
   logic [7:0] stack_rdata;
   logic stack_we;
   logic [ptc_pkg::STACK_AW-1:0] stack_raddr;

   // ----------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------
   function automatic logic [31:0] read_word(input logic [7:0] a);
      logic [31:0] d;
      logic [ptc_pkg::SRC_IDX_W-1:0] idx;
      d = 32'h0000_0000;
      idx = a[ptc_pkg::SRC_IDX_W+1:2];
      if (a == ptc_pkg::OFS_FIRST_INT_CTRL) begin
         d[ptc_pkg::NEST_DIS_BIT] = s.nesting_disable;
         d[ptc_pkg::NUM_TRAP-1:0] = s.trap_flag;
      end else if (a == ptc_pkg::OFS_FLAG_BANK) begin
         d[ptc_pkg::NUM_SRC-1:0] = s.flag;
      end else if (a == ptc_pkg::OFS_ENABLE_BANK) begin
         d[ptc_pkg::NUM_SRC-1:0] = s.en;
      end else if (a == ptc_pkg::OFS_CTRL_STATUS) begin
         d[ptc_pkg::NEW_LVL_MSB:ptc_pkg::NEW_LVL_LSB] = s.new_cpu_level; // R05
         d[ptc_pkg::VEC_MSB:0] = s.pending_vector_code; // R06
      end else if (a == ptc_pkg::OFS_STATUS_LOW) begin
         d[7:0] = s.stat_low;
      end else if (a == ptc_pkg::OFS_TIMED_DISABLE) begin
         d[15:0] = s.tdis_cnt;
      end else if (a == ptc_pkg::OFS_EVT_STATUS) begin
         d[2:0] = s.evt_st;
      end else if (a == ptc_pkg::OFS_EVT_MASK) begin
         d[2:0] = s.evt_mask;
      end else if (a >= ptc_pkg::OFS_PRIO_BANK && a <= ptc_pkg::OFS_PRIO_LAST) begin
         d[ptc_pkg::PRIO_MSB:ptc_pkg::PRIO_LSB] = s.prio[idx]; // R01 R04
      end
      return d;
   endfunction : read_word

   // ----------------------------------------------------------------
   // Per-source request qualification
   // ----------------------------------------------------------------
   logic [ptc_pkg::NUM_SRC-1:0] src_req;
   logic tdis_active;
   logic nest_hold;

   // Timed disable lets only the top user level through
   assign tdis_active = s.tdis_cnt != 16'h0000; // R14
   // Nesting off: no user source may preempt a routine in service
   assign nest_hold = s.nesting_disable && s.depth != '0; // R07

   for (genvar g = 0; g < ptc_pkg::NUM_SRC; g++) begin : g_src
      logic armed;
      logic coded;
      logic held;
      assign armed = s.flag[g] & s.en[g]; // R08 R09
      assign coded = s.prio[g] != ptc_pkg::PRIO_OFF; // R02
      assign held = nest_hold | (tdis_active & (s.prio[g] != ptc_pkg::PRIO_TOP_USER)); // R14 R07
      assign src_req[g] = armed & coded & ~held;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [3:0] best_lvl;
      logic [6:0] best_code;
      logic [3:0] lvl;
      logic [3:0] cur_lvl;
      logic user_ok;
      logic grant_ok;
      logic wr;
      logic take;
      logic [7:0] wa;
      logic [ptc_pkg::SRC_IDX_W-1:0] widx;
      logic [ptc_pkg::NUM_SRC-1:0] flag_clr;
      logic [ptc_pkg::NUM_TRAP-1:0] trap_clr;
      logic [2:0] evt_clr;
      logic [2:0] evt_set;
      best_lvl = 4'h0;
      best_code = 7'h00;
      lvl = 4'h0;
      cur_lvl = s.stat_low[ptc_pkg::STAT_LVL_MSB:ptc_pkg::STAT_LVL_LSB];
      user_ok = 1'b0;
      grant_ok = 1'b0;
      wr = s.ap_valid & s.ap_write;
      take = s.cpu_irq & cpu_take;
      wa = s.ap_addr;
      widx = wa[ptc_pkg::SRC_IDX_W+1:2];
      flag_clr = '0;
      trap_clr = '0;
      evt_clr = 3'h0;
      evt_set = 3'h0;
      next_s = s;
      stack_we = 1'b0;

      // Arbitration: strict compare keeps the first, lowest-numbered winner
      for (int i = 0; i < ptc_pkg::NUM_SRC; i++) begin
         lvl = {1'b0, s.prio[i]};
         user_ok = src_req[i];
         if (user_ok && lvl > best_lvl) begin // R15
            best_lvl = lvl;
            best_code = 7'(i);
         end
      end
      // Traps ignore every disable; only a level in service at or above theirs holds them
      for (int j = 0; j < ptc_pkg::NUM_TRAP; j++) begin
         lvl = ptc_pkg::TRAP_LVL_BASE + 4'(j);
         if (s.trap_flag[j] && lvl > best_lvl) begin // R11 R13
            best_lvl = lvl;
            best_code = ptc_pkg::TRAP_CODE_BASE + 7'(j);
         end
      end
      grant_ok = best_lvl > cur_lvl; // R12 R15

      // Bus address phase; read data is ready for the data phase
      next_s.hreadyout = 1'b1;
      next_s.hresp = 1'b0;
      next_s.ap_valid = hsel & htrans[1] & hready;
      next_s.ap_write = hwrite;
      next_s.ap_addr = haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
         next_s.hrdata = read_word(haddr[7:0]);
      end

      // Bus data phase writes
      if (wr) begin
         if (wa == ptc_pkg::OFS_FIRST_INT_CTRL) begin
            next_s.nesting_disable = hwdata[ptc_pkg::NEST_DIS_BIT];
            trap_clr = hwdata[ptc_pkg::NUM_TRAP-1:0];
         end else if (wa == ptc_pkg::OFS_FLAG_BANK) begin
            flag_clr = hwdata[ptc_pkg::NUM_SRC-1:0];
         end else if (wa == ptc_pkg::OFS_ENABLE_BANK) begin
            next_s.en = hwdata[ptc_pkg::NUM_SRC-1:0];
         end else if (wa == ptc_pkg::OFS_STATUS_LOW) begin
            // Top level bit belongs to hardware so software cannot enter trap levels
            next_s.stat_low = hwdata[7:0];
            next_s.stat_low[ptc_pkg::STAT_HW_BIT] = s.stat_low[ptc_pkg::STAT_HW_BIT]; // R12
         end else if (wa == ptc_pkg::OFS_TIMED_DISABLE) begin
            next_s.tdis_cnt = hwdata[15:0];
         end else if (wa == ptc_pkg::OFS_EVT_STATUS) begin
            evt_clr = hwdata[2:0];
         end else if (wa == ptc_pkg::OFS_EVT_MASK) begin
            next_s.evt_mask = hwdata[2:0];
         end else if (wa >= ptc_pkg::OFS_PRIO_BANK && wa <= ptc_pkg::OFS_PRIO_LAST) begin
            next_s.prio[widx] = hwdata[ptc_pkg::PRIO_MSB:ptc_pkg::PRIO_LSB]; // R01 R04
         end
      end

      // Timed disable countdown
      if (!(wr && wa == ptc_pkg::OFS_TIMED_DISABLE) && s.tdis_cnt != 16'h0000) begin
         next_s.tdis_cnt = s.tdis_cnt - 16'h0001; // R14
      end

      // Sticky flags: a new event wins over a clear in the same cycle
      next_s.flag = (s.flag & ~flag_clr) | src_evt; // R09
      next_s.trap_flag = (s.trap_flag & ~trap_clr) | trap_evt; // R11

      // Grant and return; a push beyond the stack is refused
      if (take && s.depth != 5'(ptc_pkg::STACK_DEPTH)) begin
         stack_we = 1'b1;
         next_s.stat_low[ptc_pkg::STAT_LVL_MSB:ptc_pkg::STAT_LVL_LSB] = s.pend_lvl; // R16
         next_s.depth = s.depth + 5'h01;
         evt_set[ptc_pkg::EVT_GRANT] = 1'b1;
      end else if (cpu_return && s.depth != '0) begin
         next_s.stat_low = stack_rdata; // R10
         next_s.depth = s.depth - 5'h01;
         evt_set[ptc_pkg::EVT_RETURN] = 1'b1;
      end
      evt_set[ptc_pkg::EVT_TRAP] = |trap_evt;

      // Status word follows the new level at once; the CPU request is cleared on a grant or return
      next_s.new_cpu_level = next_s.stat_low[ptc_pkg::STAT_LVL_MSB:ptc_pkg::STAT_LVL_LSB]; // R05 R16
      next_s.pending_vector_code = best_code; // R06
      next_s.pend_lvl = best_lvl;
      next_s.cpu_irq = grant_ok & ~take & ~(cpu_return & s.depth != '0);

      next_s.evt_st = (s.evt_st & ~evt_clr) | evt_set;
      next_s.irq = |(next_s.evt_st & next_s.evt_mask);
   end

   assign stack_raddr = 4'(s.depth - 5'h01);

   // ----------------------------------------------------------------
   // Saved status stack
   // ----------------------------------------------------------------
   ptc_stack_mem u_stack (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .we(stack_we),
      .waddr(s.depth[ptc_pkg::STACK_AW-1:0]),
      .wdata(s.stat_low),
      .raddr(stack_raddr),
      .rdata(stack_rdata)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s <= RST;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign hrdata = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;
   assign cpu_irq = s.cpu_irq;
   assign cpu_vector_code = s.pending_vector_code;
   assign cpu_level = s.new_cpu_level;
   assign irq = s.irq;

   // hsize is accepted but only whole-word transfers are supported
   logic unused_ok;
   assign unused_ok = &{1'b0, hsize, haddr[31:8], 1'b0};

endmodule : ptc_ctrl

`default_nettype wire

// >>> ptc_pkg.sv
package ptc_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_SRC = 8;
   localparam int NUM_TRAP = 4;
   localparam int STACK_DEPTH = 16;
   localparam int STACK_AW = 4;
   localparam int SRC_IDX_W = 3;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_FIRST_INT_CTRL = 8'h00;
   localparam logic [7:0] OFS_FLAG_BANK = 8'h04;
   localparam logic [7:0] OFS_ENABLE_BANK = 8'h08;
   localparam logic [7:0] OFS_CTRL_STATUS = 8'h0c;
   localparam logic [7:0] OFS_STATUS_LOW = 8'h10;
   localparam logic [7:0] OFS_TIMED_DISABLE = 8'h14;
   localparam logic [7:0] OFS_EVT_STATUS = 8'h18;
   localparam logic [7:0] OFS_EVT_MASK = 8'h1c;
   // Source 0 is the sense unit: its priority word is the first of the bank
   localparam logic [7:0] OFS_SENSE_UNIT_PRIO = 8'h20;
   localparam logic [7:0] OFS_PRIO_BANK = 8'h20;
   localparam logic [7:0] OFS_PRIO_LAST = 8'h3c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int NEST_DIS_BIT = 15;
   localparam int PRIO_LSB = 4;
   localparam int PRIO_MSB = 6;
   localparam int NEW_LVL_LSB = 8;
   localparam int NEW_LVL_MSB = 11;
   localparam int VEC_MSB = 6;
   localparam int STAT_LVL_LSB = 1;
   localparam int STAT_LVL_MSB = 4;
   localparam int STAT_HW_BIT = 4;
   localparam int EVT_GRANT = 0;
   localparam int EVT_RETURN = 1;
   localparam int EVT_TRAP = 2;

   // ----------------------------------------------------------------
   // Levels, codes and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] PRIO_RESET = 3'h4;
   localparam logic [2:0] PRIO_OFF = 3'h0;
   localparam logic [2:0] PRIO_TOP_USER = 3'h7;
   localparam logic [3:0] TRAP_LVL_BASE = 4'hc;
   localparam logic [6:0] TRAP_CODE_BASE = 7'h70;
   localparam logic [7:0] STAT_LOW_RESET = 8'h00;
   localparam logic [15:0] TDIS_RESET = 16'h0000;
   localparam logic [2:0] EVT_MASK_RESET = 3'h0;

endpackage : ptc_pkg

// >>> ptc_stack_mem.sv
`timescale 1ns/1ps
`default_nettype none

module ptc_stack_mem (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic we,
   input wire logic [ptc_pkg::STACK_AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [ptc_pkg::STACK_AW-1:0] raddr,
   output logic [7:0] rdata
);

   typedef struct packed {
      logic [ptc_pkg::STACK_DEPTH-1:0][7:0] mem;
      logic [7:0] rdata;
   } ptc_mem_s;

   ptc_mem_s s;
   ptc_mem_s next_s;

   always_comb begin
      next_s = s;
      next_s.rdata = s.mem[raddr];
      if (we) begin
         next_s.mem[waddr] = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;

endmodule : ptc_stack_mem

`default_nettype wire

// >>> ptc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none

module ptc_ctrl_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic cpu_take,
   input wire logic cpu_irq,
   input wire logic [6:0] cpu_vector_code,
   input wire logic [3:0] cpu_level
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   logic tk;
   logic [6:0] code_q;
   assign tk = ce && cpu_take && cpu_irq;
   always_ff @(posedge clk) begin
      code_q <= cpu_vector_code;
   end

   reset_clear_a: assert property ($past(rst_b) == 1'b0 |-> cpu_level == 4'h0 && !cpu_irq)
      else $error("outputs not cleared by reset");
   grant_above_a: assert property (tk |=> cpu_level > $past(cpu_level))
      else $error("grant did not raise the level");
   grant_drop_a: assert property (tk |=> !cpu_irq)
      else $error("request not dropped after grant");
   trap_level_a: assert property (tk && cpu_vector_code[6:4] == 3'h7 |=> cpu_level == {2'b11, code_q[1:0]})
      else $error("trap granted at wrong level");
   user_level_a: assert property (tk && cpu_vector_code < 7'h70 |=> cpu_level inside {[4'h1:4'h7]})
      else $error("user grant outside levels 1 to 7");
   // Level held two samples so the registered request saw it
   user_mask_a: assert property (cpu_level >= 4'h7 [*2] |-> !(cpu_irq && cpu_vector_code < 7'h70))
      else $error("user request above level 7 mask");
   code_range_a: assert property (cpu_irq |-> cpu_vector_code < 7'h08 || cpu_vector_code[6:2] == 5'h1c)
      else $error("pending code out of range");
   level_cap_a: assert property (cpu_irq |-> cpu_level != 4'hf)
      else $error("request above level 15");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
endmodule : ptc_ctrl_checker

bind ptc_ctrl ptc_ctrl_checker chk_u (.clk, .rst_b, .ce, .hreadyout, .hresp, .cpu_take, .cpu_irq,
   .cpu_vector_code, .cpu_level);

`default_nettype wire

// >>> ptc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module ptc_cpu_model (
   input wire logic clk,
   input wire logic cpu_irq,
   input wire logic take_en,
   input wire logic [3:0] lat,
   output logic cpu_take
);
   int w = 0;
   initial cpu_take = 1'b0;
   // Slow core: accepts only after lat cycles of a standing request
   always @(posedge clk) begin
      cpu_take <= 1'b0;
      if (take_en && cpu_irq && cpu_take !== 1'b1) begin
         if (w >= lat) begin
            cpu_take <= 1'b1;
            w <= 0;
         end else begin
            w <= w + 1;
         end
      end else begin
         w <= 0;
      end
   end
endmodule : ptc_cpu_model

`default_nettype wire

// >>> ptc_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none

module ptc_ctrl_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] src_evt = 8'h0;
   logic [3:0] trap_evt = 4'h0;
   logic cpu_return = 1'b0;
   logic take_en = 1'b0;
   logic [3:0] lat = 4'h0;
   logic [31:0] hrdata, v;
   logic hreadyout, hresp, cpu_take, cpu_irq, irq;
   logic [6:0] cpu_vector_code;
   logic [3:0] cpu_level;
   int n_fail = 0;
   int num_checks = 0;
   int prio[8];
   int fl, en, c, l, i, k;

   always #50 clk = ~clk;

   ptc_ctrl dut (.clk, .rst_b, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .src_evt, .trap_evt, .cpu_take,
      .cpu_return, .cpu_irq, .cpu_vector_code, .cpu_level, .irq);
   ptc_cpu_model cpu (.clk, .cpu_irq, .take_en, .lat, .cpu_take);

   task automatic conclude;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step

   task automatic hw;
      int t;
      for (t = 0; t < 20; t++) begin
         @(posedge clk);
         if (hreadyout === 1'b1) break;
      end
      if (t == 20) begin
         n_fail++;
         conclude();
      end
   endtask : hw

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      hw();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hw();
      v = hrdata;
   endtask : bus

   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, v);
   endtask : rc

   task automatic ev(input logic [7:0] s, input logic [3:0] t);
      @(posedge clk);
      src_evt <= s;
      trap_evt <= t;
      @(posedge clk);
      src_evt <= 8'h0;
      trap_evt <= 4'h0;
      fl = fl | s;
   endtask : ev

   task automatic take(input int el);
      int t;
      take_en <= 1'b1;
      for (t = 0; t < 20 && cpu_take !== 1'b1; t++) @(negedge clk);
      take_en <= 1'b0;
      if (t == 20) begin
         n_fail++;
         conclude();
      end
      step(1);
      chk("level", el, cpu_level);
      chk("drop", 0, cpu_irq);
   endtask : take

   task automatic ret(input int el);
      @(posedge clk);
      cpu_return <= 1'b1;
      @(posedge clk);
      cpu_return <= 1'b0;
      step(1);
      chk("restored", el, cpu_level);
   endtask : ret

   // Highest level wins, lowest index on a tie
   function automatic void best(input int cur, output int bc, output int bl);
      bc = 0;
      bl = 0;
      for (int j = 7; j >= 0; j--) begin
         if (en[j] && fl[j] && prio[j] != 0 && prio[j] >= bl) begin
            bc = j;
            bl = prio[j];
         end
      end
      if (bl <= cur) bl = 0;
   endfunction : best

   initial begin
      void'($urandom(33));
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      for (i = 0; i < 8; i++) rc("prio rst", 8'h20 + 8'(4 * i), 32'h40);
      rc("status", 8'h0c, 32'h0);
      rc("unmapped", 8'hfc, 32'h0);
      for (k = 0; k < 12; k++) begin
         for (i = 0; i < 8; i++) begin
            prio[i] = $urandom_range(7, 0);
            bus(1'b1, 8'h20 + 8'(4 * i), $urandom() & 32'hffffff8f | 32'(prio[i]) << 4);
         end
         rc("prio0", 8'h20, 32'(prio[0]) << 4);
         en = $urandom_range(255, 0);
         bus(1'b1, 8'h08, 32'(en));
         lat <= 4'($urandom_range(3, 0));
         fl = 0;
         ev(8'($urandom_range(255, 1)), 4'h0);
         step(2);
         best(0, c, l);
         chk("request", l > 0, cpu_irq);
         if (l > 0) begin
            chk("code", c, cpu_vector_code);
            take(l);
            rc("status", 8'h0c, 32'(l << 8 | c));
            ret(0);
            step(1);
            chk("again", 1, cpu_irq);
         end
         bus(1'b1, 8'h04, 32'hff);
      end
      bus(1'b1, 8'h00, 32'h8000);
      bus(1'b1, 8'h24, 32'h20);
      bus(1'b1, 8'h28, 32'h50);
      bus(1'b1, 8'h08, 32'h6);
      ev(8'h02, 4'h0);
      step(2);
      take(2);
      ev(8'h04, 4'h2);
      step(2);
      chk("trap code", 32'h71, cpu_vector_code);
      take(13);
      ret(2);
      step(1);
      chk("trap again", 32'h71, cpu_vector_code);
      chk("trap irq", 1, cpu_irq);
      bus(1'b1, 8'h00, 32'h8002);
      step(2);
      chk("nested", 0, cpu_irq);
      ret(0);
      step(1);
      chk("resume", 2, cpu_vector_code);
      bus(1'b1, 8'h04, 32'hff);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h24, 32'h70);
      bus(1'b1, 8'h10, 32'h0e);
      rc("lvl7", 8'h0c, 32'h700);
      ev(8'h02, 4'h0);
      step(2);
      chk("masked", 0, cpu_irq);
      ev(8'h00, 4'h1);
      step(2);
      chk("trap7", 32'h70, cpu_vector_code);
      chk("trap7 irq", 1, cpu_irq);
      bus(1'b1, 8'h00, 32'h1);
      bus(1'b1, 8'h10, 32'h0);
      step(2);
      chk("unmasked", 1, cpu_irq);
      bus(1'b1, 8'h04, 32'hff);
      bus(1'b1, 8'h28, 32'h60);
      bus(1'b1, 8'h14, 32'd40);
      ev(8'h04, 4'h0);
      step(2);
      chk("disabled", 0, cpu_irq);
      ev(8'h02, 4'h0);
      step(2);
      chk("lvl7 pass", 1, cpu_irq);
      bus(1'b1, 8'h04, 32'h02);
      step(2);
      chk("still off", 0, cpu_irq);
      step(40);
      chk("expired", 1, cpu_irq);
      bus(1'b1, 8'h0c, 32'hffffffff);
      rc("read only", 8'h0c, 32'h2);
      chk("irq masked", 0, irq);
      bus(1'b1, 8'h1c, 32'h1);
      step(2);
      chk("irq", 1, irq);
      bus(1'b1, 8'h18, 32'h7);
      step(2);
      chk("irq clear", 0, irq);
      // Clock enable low: a trap event must be lost, state frozen
      @(posedge clk);
      ce <= 1'b0;
      ev(8'h00, 4'h4);
      @(posedge clk);
      ce <= 1'b1;
      step(2);
      chk("frozen", 32'h2, cpu_vector_code);
      conclude();
   end
endmodule : ptc_ctrl_bench

`default_nettype wire
